// [design/lane_ram.sv]
`timescale 1ns/1ns
`default_nettype none

module lane_ram
   import sram_ctrl_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              rd_en,
   input  wire logic [LANES-1:0]  wr_lanes,
   input  wire word_t             wdata,
   output word_t                  rdata
);

   // ------------------------------------------------------------
   // One array per byte lane, parity bit kept with its byte
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_DATA_W:0] mem [0:(1<<ADDR_W)-1];
         logic [LANE_DATA_W:0] rd_q;

         always_ff @(posedge clk_sys) begin
            if (clk_en) begin
               if (wr_lanes[g]) begin
                  mem[addr] <= {wdata.par[g], wdata.dat[g*LANE_DATA_W +: LANE_DATA_W]};
               end
               if (rd_en) begin
                  rd_q <= mem[addr];
               end
            end
         end

         assign rdata.par[g]                            = rd_q[LANE_DATA_W];
         assign rdata.dat[g*LANE_DATA_W +: LANE_DATA_W] = rd_q[LANE_DATA_W-1:0];
      end
   endgenerate

endmodule // lane_ram

`default_nettype wire

// [design/sram_ctrl_pkg.sv]
package sram_ctrl_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ADDR_W_DEF  = 18;
   localparam int LANES       = 2;
   localparam int LANE_DATA_W = 8;
   localparam int BURST_W     = 2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 10000;
   localparam int CLOCK_TO_DATA_PS   = 7500;
   // Longest time rounds down, but never below one cycle
   localparam int CLOCK_TO_DATA_CYC  = (CLOCK_TO_DATA_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                       (CLOCK_TO_DATA_PS / CLK_PERIOD_PS);
   localparam int SYNC_STAGES        = 2;
   localparam int SLEEP_ENTRY_CYC    = 2;
   localparam int BUF_DEPTH          = 2;

   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANES-1:0]   LANES_ALL  = 2'h3;
   localparam logic [LANES-1:0]   LANES_NONE = 2'h0;
   localparam logic               MODE_INTERLEAVED = 1'b1;

   typedef struct packed {
      logic [LANES-1:0]             par;
      logic [LANES*LANE_DATA_W-1:0] dat;
   } word_t;

   localparam word_t WORD_RST = '0;

   typedef struct packed {
      logic             select_first_n;
      logic             select_second;
      logic             select_third_n;
      logic             processor_addr_strobe_n;
      logic             controller_addr_strobe_n;
      logic             burst_advance_n;
      logic             byte_write_qualifier_n;
      logic [LANES-1:0] byte_lane_select_n;
      logic             global_write_n;
      logic             output_enable_n;
      logic             sleep_request;
      logic             burst_order_mode;
   } ctrl_t;

   // Idle level of every control pin, used at reset
   localparam ctrl_t CTRL_RST = '{select_first_n: 1'b1, select_second: 1'b0,
                                  select_third_n: 1'b1, processor_addr_strobe_n: 1'b1,
                                  controller_addr_strobe_n: 1'b1, burst_advance_n: 1'b1,
                                  byte_write_qualifier_n: 1'b1, byte_lane_select_n: 2'h3,
                                  global_write_n: 1'b1, output_enable_n: 1'b1,
                                  sleep_request: 1'b0, burst_order_mode: 1'b1};

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_PFIRST = 4'b0010,
      ST_BURST  = 4'b0100,
      ST_SLEEP  = 4'b1000
   } state_t;

endpackage

// [design/sync_burst_cache_ram_ctrl.sv]
// Behaviour
// - Register all synchronous inputs on rising edge
// - Order pin: low linear, high interleaved
// - Two-bit wrapping counter loaded from address
// - Interleaved: start XOR step 00..11
// - Linear: start plus step modulo four
// - Counter steps only under burst advance
// - Advance low steps, high suspends burst
// - Selected strobe low starts read, latches address
// - First, third selects low; second high
// - Read data driven after rise, output enabled
// - Drive data only while output enable low
// - Processor strobe: ignore writes first cycle
// - Controller strobe with write starts write
// - Controller-strobe write stores same-cycle data
// - Qualifier plus lane selects gate bytes
// - Lane 0 low byte, lane 1 high
// - Global write writes every lane
// - Write detected forces data pins off
// - Sleep entry and exit take three cycles
// - Sleep keeps contents, drops pending access
`timescale 1ns/1ns
`default_nettype none

module sync_burst_cache_ram_ctrl
   import sram_ctrl_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              select_first_n,
   input  wire logic              select_second,
   input  wire logic              select_third_n,
   input  wire logic              processor_addr_strobe_n,
   input  wire logic              controller_addr_strobe_n,
   input  wire logic              burst_advance_n,
   input  wire logic              byte_write_qualifier_n,
   input  wire logic [LANES-1:0]  byte_lane_select_n,
   input  wire logic              global_write_n,
   input  wire logic              output_enable_n,
   input  wire logic              sleep_request,
   input  wire logic              burst_order_mode,
   input  wire word_t             data_i,
   output word_t                  data_o,
   output logic                   data_oe,
   input  wire logic              rd_ready,
   output logic                   rd_valid,
   output logic                   accept_ready,
   output logic                   sleep_active
);

   // ------------------------------------------------------------
   // Input registers: two stages, only the second stage reads the first
   // ------------------------------------------------------------
   ctrl_t             ctrl_pin;
   ctrl_t             ctrl_s1_q, ctrl_q;
   logic [ADDR_W-1:0] addr_s1_q, addr_q;
   word_t             din_s1_q, din_q;

   assign ctrl_pin = '{select_first_n: select_first_n, select_second: select_second,
                       select_third_n: select_third_n,
                       processor_addr_strobe_n: processor_addr_strobe_n,
                       controller_addr_strobe_n: controller_addr_strobe_n,
                       burst_advance_n: burst_advance_n,
                       byte_write_qualifier_n: byte_write_qualifier_n,
                       byte_lane_select_n: byte_lane_select_n,
                       global_write_n: global_write_n, output_enable_n: output_enable_n,
                       sleep_request: sleep_request, burst_order_mode: burst_order_mode};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_s1_q <= CTRL_RST;
         ctrl_q    <= CTRL_RST;
         addr_s1_q <= '0;
         addr_q    <= '0;
         din_s1_q  <= WORD_RST;
         din_q     <= WORD_RST;
      end else if (clk_en) begin
         ctrl_s1_q <= ctrl_pin;
         ctrl_q    <= ctrl_s1_q;
         addr_s1_q <= addr;
         addr_q    <= addr_s1_q;
         din_s1_q  <= data_i;
         din_q     <= din_s1_q;
      end
   end

   // ------------------------------------------------------------
   // Cycle decode
   // ------------------------------------------------------------
   state_t           state_q, state_d;
   logic             selected, proc_low, ctrl_low, strobe, start, deselect, cont;
   logic             wr_ind, can_issue, asleep;
   logic [LANES-1:0] lanes_ind;

   assign asleep   = (state_q == ST_SLEEP);
   assign selected = !ctrl_q.select_first_n && ctrl_q.select_second
                     && !ctrl_q.select_third_n;
   // Processor strobe only counts while the first select is low
   assign proc_low = !ctrl_q.processor_addr_strobe_n && !ctrl_q.select_first_n;
   // Controller strobe is ignored while the processor strobe counts
   assign ctrl_low = !ctrl_q.controller_addr_strobe_n && !proc_low;
   assign strobe   = proc_low || ctrl_low;
   assign start    = strobe && selected && !asleep;
   assign deselect = strobe && !selected;
   assign cont     = !strobe && !asleep
                     && (state_q == ST_PFIRST || state_q == ST_BURST);

   always_comb begin
      if (!ctrl_q.global_write_n) begin
         lanes_ind = LANES_ALL;
      end else if (!ctrl_q.byte_write_qualifier_n) begin
         lanes_ind = ~ctrl_q.byte_lane_select_n;
      end else begin
         lanes_ind = LANES_NONE;
      end
   end

   assign wr_ind = (lanes_ind != LANES_NONE);

   // ------------------------------------------------------------
   // Burst counter
   // ------------------------------------------------------------
   logic [ADDR_W-1:0]  hi_q;
   logic [BURST_W-1:0] base_q, step_q, step_nxt, low_nxt;
   logic [ADDR_W-1:0]  mem_addr;
   logic               rd_issue, wr_issue;
   logic [LANES-1:0]   wr_lanes;

   // Suspend repeats the current address
   assign step_nxt = ctrl_q.burst_advance_n ? step_q : step_q + BURST_STEP;

   always_comb begin
      if (ctrl_q.burst_order_mode == MODE_INTERLEAVED) begin
         low_nxt = base_q ^ step_nxt;
      end else begin
         low_nxt = base_q + step_nxt;
      end
   end

   // Processor-strobe start is always a read; write inputs are ignored
   assign rd_issue = can_issue && ((start && (proc_low || !wr_ind))
                                   || (cont && !wr_ind));
   assign wr_issue = (start && ctrl_low && wr_ind) || (cont && wr_ind);
   assign wr_lanes = wr_issue ? lanes_ind : LANES_NONE;

   always_comb begin
      if (start) begin
         mem_addr = addr_q;
      end else begin
         mem_addr = {hi_q[ADDR_W-1:BURST_W], low_nxt};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hi_q   <= '0;
         base_q <= BURST_RST;
         step_q <= BURST_RST;
      end else if (clk_en) begin
         if (start && (rd_issue || wr_issue)) begin
            hi_q   <= addr_q;
            base_q <= addr_q[BURST_W-1:0];
            step_q <= BURST_RST;
         end else if (cont && (rd_issue || wr_issue)) begin
            // A stalled read keeps the counter where it is
            step_q <= step_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // Access state
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SLEEP: begin
            if (!ctrl_q.sleep_request) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            if (ctrl_q.sleep_request) begin
               // Any pending burst is dropped on entry
               state_d = ST_SLEEP;
            end else if (deselect) begin
               state_d = ST_IDLE;
            end else if (start && (rd_issue || wr_issue)) begin
               state_d = proc_low ? ST_PFIRST : ST_BURST;
            end else if (cont && state_q == ST_PFIRST) begin
               state_d = ST_BURST;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   assign sleep_active = asleep;

   // ------------------------------------------------------------
   // Array; contents untouched by sleep
   // ------------------------------------------------------------
   word_t mem_rdata;
   logic  rd_done_q;

   lane_ram #(
      .ADDR_W (ADDR_W)
   ) u_ram (
      .clk_sys  (clk_sys),
      .clk_en   (clk_en),
      .addr     (mem_addr),
      .rd_en    (rd_issue),
      .wr_lanes (wr_lanes),
      .wdata    (din_q),
      .rdata    (mem_rdata)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_done_q <= 1'b0;
      end else if (clk_en) begin
         rd_done_q <= rd_issue;
      end
   end

   // ------------------------------------------------------------
   // Two-entry read buffer
   // ------------------------------------------------------------
   word_t      buf_q [BUF_DEPTH];
   logic [1:0] cnt_q;
   logic       wr_ptr_q, rd_ptr_q, push, pop;

   assign push     = rd_done_q;
   assign rd_valid = (cnt_q != 2'h0);
   assign pop      = rd_valid && rd_ready;
   // Reads are held back unless the word in flight still fits
   assign can_issue    = (cnt_q == 2'h0) || ((cnt_q == 2'h1) && !rd_done_q);
   assign accept_ready = can_issue;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         buf_q[0] <= WORD_RST;
         buf_q[1] <= WORD_RST;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end else if (clk_en) begin
         if (push) begin
            buf_q[wr_ptr_q] <= mem_rdata;
            wr_ptr_q        <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Data pins
   // ------------------------------------------------------------
   logic drive_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         data_o <= WORD_RST;
      end else if (clk_en && pop) begin
         data_o <= buf_q[rd_ptr_q];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         drive_q <= 1'b0;
      end else if (clk_en) begin
         if (wr_issue || asleep || ctrl_q.sleep_request) begin
            drive_q <= 1'b0;
         end else if (pop) begin
            drive_q <= 1'b1;
         end
      end
   end

   // Write detection beats output enable so the bus cannot fight the host
   assign data_oe = drive_q && !ctrl_q.output_enable_n && !wr_issue && !asleep;

endmodule // sync_burst_cache_ram_ctrl

`default_nettype wire

// [tb/host_side_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------
// Reader and shared bus
// ----------
module host_side_model
   import sram_ctrl_pkg::*;
(
   input  wire logic  clk_sys,
   input  wire logic  stall,
   input  wire logic  rd_valid,
   input  wire word_t data_o,
   input  wire logic  data_oe,
   input  wire word_t host_data,
   input  wire logic  host_drive,
   output var  logic  rd_ready,
   output var  word_t bus
);
   word_t got[$];
   word_t last_q = '0;
   logic  pop_q  = 1'b0;
   assign rd_ready = !stall;
   // Released bus toggles so a kept value can never pass for data
   assign bus = host_drive ? host_data : (data_oe ? data_o : ~last_q);
   // Plain always: the bench also empties the queue between scenarios
   always @(posedge clk_sys) begin
      last_q <= bus;
      pop_q  <= rd_valid && rd_ready;
      if (pop_q) begin
         got.push_back(data_o);
      end
   end
endmodule // host_side_model
`default_nettype wire

// [tb/ram_ctrl_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------
// Port checks
// ----------
module ram_ctrl_checker
   import sram_ctrl_pkg::*;
(
   input wire logic  clk_sys,
   input wire logic  resetn,
   input wire logic  select_first_n,
   input wire logic  select_second,
   input wire logic  select_third_n,
   input wire logic  processor_addr_strobe_n,
   input wire logic  controller_addr_strobe_n,
   input wire logic  global_write_n,
   input wire logic  output_enable_n,
   input wire logic  sleep_request,
   input wire word_t data_o,
   input wire logic  data_oe,
   input wire logic  rd_ready,
   input wire logic  rd_valid,
   input wire logic  sleep_active
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic wr_pin;
   // Pins act two edges after they are sampled
   assign wr_pin = !select_first_n && select_second && !select_third_n && !global_write_n
                   && processor_addr_strobe_n && !controller_addr_strobe_n;
   write_offbus_a: assert property ($past(wr_pin, 2) |-> !data_oe)
      else $error("bus driven in a write cycle");
   oe_gate_a: assert property (data_oe |-> !$past(output_enable_n, 2))
      else $error("bus driven without output enable");
   sleep_quiet_a: assert property (sleep_active && $past(sleep_active) |-> !data_oe)
      else $error("bus driven while asleep");
   sleep_entry_a: assert property ($rose(sleep_request) |-> ##[2:4] sleep_active)
      else $error("sleep not entered in time");
   sleep_exit_a: assert property ($fell(sleep_request) |-> ##[2:4] !sleep_active)
      else $error("sleep not left in time");
   sleep_delay_a: assert property ($rose(sleep_request) |-> !sleep_active [*2])
      else $error("sleep entered too early");
   data_hold_a: assert property ($changed(data_o) |-> $past(rd_valid && rd_ready))
      else $error("read data changed without a pop");
   word_kept_a: assert property (rd_valid && !rd_ready |=> rd_valid)
      else $error("buffered word lost under stall");
   cover property (wr_pin);
   cover property (rd_valid && rd_ready);
   cover property ($rose(sleep_active));
endmodule // ram_ctrl_checker

bind sync_burst_cache_ram_ctrl ram_ctrl_checker u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .select_first_n(select_first_n),
   .select_second(select_second), .select_third_n(select_third_n),
   .processor_addr_strobe_n(processor_addr_strobe_n),
   .controller_addr_strobe_n(controller_addr_strobe_n), .global_write_n(global_write_n),
   .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_o(data_o),
   .data_oe(data_oe), .rd_ready(rd_ready), .rd_valid(rd_valid), .sleep_active(sleep_active));
`default_nettype wire

// [tb/test_sync_burst_cache_ram_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------
// Bench
// ----------
module test_sync_burst_cache_ram_ctrl
   import sram_ctrl_pkg::*;
;
   localparam int AW = 6;
   logic          clk_sys = 1'b0;
   logic          resetn  = 1'b0;
   ctrl_t         pin     = CTRL_RST;
   logic [AW-1:0] addr    = '0;
   word_t         hdat    = '0;
   logic          hdrv    = 1'b0;
   logic          stall   = 1'b0;
   logic          by_ctl  = 1'b0;
   word_t         data_i, data_o;
   logic          data_oe, rd_ready, rd_valid, accept_ready, sleep_active;
   word_t         mem[0:63];
   word_t         runs[$];
   int            err_total = 0;
   int            checks_done = 0;

   initial forever #5 clk_sys = ~clk_sys;

   sync_burst_cache_ram_ctrl #(.ADDR_W(AW)) DUT (
      .clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .addr(addr),
      .select_first_n(pin.select_first_n), .select_second(pin.select_second),
      .select_third_n(pin.select_third_n),
      .processor_addr_strobe_n(pin.processor_addr_strobe_n),
      .controller_addr_strobe_n(pin.controller_addr_strobe_n),
      .burst_advance_n(pin.burst_advance_n), .byte_write_qualifier_n(pin.byte_write_qualifier_n),
      .byte_lane_select_n(pin.byte_lane_select_n), .global_write_n(pin.global_write_n),
      .output_enable_n(pin.output_enable_n), .sleep_request(pin.sleep_request),
      .burst_order_mode(pin.burst_order_mode), .data_i(data_i), .data_o(data_o),
      .data_oe(data_oe), .rd_ready(rd_ready), .rd_valid(rd_valid),
      .accept_ready(accept_ready), .sleep_active(sleep_active));

   host_side_model u_host (
      .clk_sys(clk_sys), .stall(stall), .rd_valid(rd_valid), .data_o(data_o),
      .data_oe(data_oe), .host_data(hdat), .host_drive(hdrv), .rd_ready(rd_ready),
      .bus(data_i));

   task automatic summarize();
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_w(input string what, input word_t exp, input word_t got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic cmp_b(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s exp %b got %b", what, exp, got);
      end
   endtask

   function automatic void put(input logic [AW-1:0] a, input word_t d, input logic [1:0] ln);
      if (!ln[0]) begin
         mem[a].dat[7:0] = d.dat[7:0];
         mem[a].par[0]   = d.par[0];
      end
      if (!ln[1]) begin
         mem[a].dat[15:8] = d.dat[15:8];
         mem[a].par[1]    = d.par[1];
      end
   endfunction

   task automatic quiet();
      pin.processor_addr_strobe_n  = 1'b1;
      pin.controller_addr_strobe_n = 1'b1;
      pin.burst_advance_n          = 1'b1;
      pin.byte_write_qualifier_n   = 1'b1;
      pin.byte_lane_select_n       = 2'h3;
      pin.global_write_n           = 1'b1;
      hdrv = 1'b0;
   endtask

   // Ends a burst; otherwise suspended reads would run on
   task automatic stop();
      quiet();
      pin.select_first_n = 1'b1;
      pin.controller_addr_strobe_n = 1'b0;
      @(negedge clk_sys);
      quiet();
      pin.select_first_n = 1'b0;
   endtask

   // A refused read only shows two edges after its pins, so retry then
   task automatic step(input logic proc, input logic [AW-1:0] a);
      for (int i = 0; i < 8; i++) begin
         pin.processor_addr_strobe_n = !proc || by_ctl;
         // Write inputs stay idle from quiet() while the controller strobe starts a read
         pin.controller_addr_strobe_n = !(proc && by_ctl);
         pin.burst_advance_n = proc;
         addr = a;
         @(negedge clk_sys);
         quiet();
         @(negedge clk_sys);
         if (accept_ready === 1'b1) break;
      end
      cmp_b("read taken", 1'b1, accept_ready);
   endtask

   task automatic wr(input logic [AW-1:0] a, input word_t d, input logic gw, input logic [1:0] ln);
      pin.controller_addr_strobe_n = 1'b0;
      pin.global_write_n = !gw;
      pin.byte_write_qualifier_n = 1'b0;
      pin.byte_lane_select_n = ln;
      addr = a;
      hdat = d;
      hdrv = 1'b1;
      @(negedge clk_sys);
      stop();
      put(a, d, gw ? 2'h0 : ln);
   endtask

   task automatic collapse();
      runs.delete();
      foreach (u_host.got[i]) begin
         if (runs.size() == 0 || runs[$] !== u_host.got[i]) runs.push_back(u_host.got[i]);
      end
   endtask

   task automatic burst(input logic [AW-1:0] a, input logic m);
      logic [1:0] lo;
      pin.burst_order_mode = m;
      pin.output_enable_n = 1'b0;
      u_host.got.delete();
      by_ctl = !m;
      step(1'b1, a);
      by_ctl = 1'b0;
      for (int i = 1; i < 4; i++) step(1'b0, a);
      stop();
      repeat (8) @(negedge clk_sys);
      collapse();
      cmp_b("run count", 1'b1, runs.size() == 4);
      for (int i = 0; i < 4; i++) begin
         lo = m ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
         cmp_w("burst word", mem[{a[AW-1:2], lo}], runs[i]);
      end
      cmp_b("drive on", 1'b1, data_oe);
      pin.output_enable_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      cmp_b("drive off", 1'b0, data_oe);
   endtask

   task automatic proc_write(input logic [AW-1:0] a, input word_t d0, input word_t d1);
      pin.processor_addr_strobe_n = 1'b0;
      pin.global_write_n = 1'b0;
      addr = a;
      hdat = d0;
      hdrv = 1'b1;
      @(negedge clk_sys);
      quiet();
      pin.byte_write_qualifier_n = 1'b0;
      pin.byte_lane_select_n = 2'h1;
      hdat = d1;
      hdrv = 1'b1;
      @(negedge clk_sys);
      stop();
      put(a, d1, 2'h1);
      repeat (6) @(negedge clk_sys);
   endtask

   task automatic fill(input logic [AW-1:0] a);
      pin.burst_order_mode = 1'b0;
      stall = 1'b1;
      u_host.got.delete();
      step(1'b1, a);
      repeat (6) @(negedge clk_sys);
      cmp_b("buffer full", 1'b0, accept_ready);
      cmp_b("word held", 1'b1, rd_valid);
      stall = 1'b0;
      step(1'b0, a);
      stop();
      repeat (8) @(negedge clk_sys);
      cmp_b("drained", 1'b0, rd_valid);
      collapse();
      cmp_w("first word", mem[a], runs[0]);
      cmp_w("next word", mem[a + 6'd1], runs[1]);
   endtask

   task automatic nap(input logic [AW-1:0] a);
      word_t old;
      pin.select_first_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      pin.sleep_request = 1'b1;
      @(negedge clk_sys);
      cmp_b("asleep early", 1'b0, sleep_active);
      repeat (3) @(negedge clk_sys);
      cmp_b("asleep", 1'b1, sleep_active);
      old = mem[a];
      // Selected while asleep, so only sleep can keep this write out
      pin.select_first_n = 1'b0;
      wr(a, ~old, 1'b1, 2'h3);
      mem[a] = old;
      pin.select_first_n = 1'b1;
      pin.sleep_request = 1'b0;
      @(negedge clk_sys);
      cmp_b("awake early", 1'b1, sleep_active);
      repeat (3) @(negedge clk_sys);
      cmp_b("awake", 1'b0, sleep_active);
      pin.select_first_n = 1'b0;
      burst(a, 1'b1);
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      summarize();
   end

   initial begin
      word_t old;
      repeat (6) @(negedge clk_sys);
      cmp_b("reset drive", 1'b0, data_oe);
      cmp_b("reset valid", 1'b0, rd_valid);
      cmp_b("reset ready", 1'b1, accept_ready);
      cmp_b("reset sleep", 1'b0, sleep_active);
      resetn = 1'b1;
      pin.select_first_n = 1'b0;
      pin.select_second = 1'b1;
      pin.select_third_n = 1'b0;
      @(negedge clk_sys);
      for (int s = 0; s < 4; s++) wr(6'(8 + s), word_t'(18'(32'h2a5c0 + s * 32'h4321)), 1'b1, 2'h2);
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 4; s++) burst(6'(8 + s), m[0]);
      end
      wr(6'd9, ~mem[9], 1'b0, 2'h2);
      pin.select_second = 1'b0;
      old = mem[8];
      wr(6'd8, ~old, 1'b1, 2'h3);
      mem[8] = old;
      pin.select_second = 1'b1;
      burst(6'd8, 1'b1);
      proc_write(6'd10, ~mem[10], word_t'(18'h1b7e4));
      burst(6'd8, 1'b0);
      fill(6'd8);
      nap(6'd11);
      summarize();
   end
endmodule // test_sync_burst_cache_ram_ctrl
`default_nettype wire
